/* File: rtl/serial_output_tag_scrambler.sv */
// Tag substitution, parity and key scrambling ahead of the serializer
//
// Behaviour
// - Selector 0 keeps bit; 1-5 give legacy tags
// - Selectors 6,7,8 flag red, green, blue pixel
// - Selector 9 gives parity over 21/14 bits
// - Selector 10 high for first sampling section
// - Selectors 11,12 give line index bits
// - Selector 13 black loop, 15 clamp closed
// - White loop flag needs its own selector
// - Config bit drops lowest pair, 14 bits remain
// - Two low remaining data bits take tags
// - Parity skips parity and one-bit key positions
// - Parity makes total ones count even
// - Tags delayed unless compensation bit set
// - Key is 21-bit maximal right-shift register
// - Key register preloads with one
// - Serial key shifts once per transmit clock
// - Parallel key jumps 21 shifts per clock
// - Mode and sub-mode fields; mode 0 passes
// - Mode 1 sub-modes mix or send keys
// - Mode 2 zeroes bit k, XORs key bit
// - Sub-mode picks key position k
// - Mode 3 XORs others with data bit k
// - Mode 3 sub-mode 1 follows pair state
// - Key starts latency cycles after line start
`include "serial_output_tag_scrambler_map.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_output_tag_scrambler
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic transmit_clock_in,
   input wire logic line_start_in,
   input wire logic [1:0] channel_mode_in,
   input wire logic [15:0] pixel_data_in,
   input wire logic [4:0] pixel_tag_bits_in,
   input wire logic red_pixel_in,
   input wire logic green_pixel_in,
   input wire logic blue_pixel_in,
   input wire logic ping_section_in,
   input wire logic [1:0] line_index_in,
   input wire logic black_loop_in,
   input wire logic white_loop_in,
   input wire logic input_clamp_switch_in,
   output logic [20:0] word_out,
   output logic word_strobe_out
);

   serial_output_tag_scrambler_pkg::state_t s_q;
   serial_output_tag_scrambler_pkg::state_t s_d;

   // ==========================================
   // Helpers
   function automatic logic [20:0] key_step(input logic [20:0] k);
      key_step = {k[0] ^ k[`KEY_TAP], k[20:1]};
   endfunction

   // Selector slots 0-4 sit on bits 0-4, slots 5-6 on bits 7-8
   function automatic logic [4:0] slot_pos(input int i);
      slot_pos = (i < `TAG_CB_POSITIONS) ? 5'(i) : 5'(i + 2);
   endfunction

   always_comb
   begin
      serial_output_tag_scrambler_pkg::tag_t tag_now;
      serial_output_tag_scrambler_pkg::tag_t tag_use;
      logic [2:0] lat;
      logic tx_rise;
      logic pair_dis;
      logic [1:0] mode;
      logic [1:0] sub;
      logic [4:0] k;
      logic [20:0] w;
      logic [20:0] par_pos;
      logic [20:0] incl;
      logic [20:0] key_par;
      logic [20:0] out;
      logic par;
      logic [4:0] p;
      tag_now = '0;
      tag_use = '0;
      lat = '0;
      tx_rise = 1'b0;
      pair_dis = 1'b0;
      mode = '0;
      sub = '0;
      k = '0;
      w = '0;
      par_pos = '0;
      incl = '0;
      key_par = '0;
      out = '0;
      par = 1'b0;
      p = '0;
      s_d = s_q;
      s_d.strobe = 1'b0;
      s_d.rdata = 8'h00;

      // ==========================================
      // Transmit clock edge finder
      s_d.tx_sync = {s_q.tx_sync[1:0], transmit_clock_in};
      if (s_q.tx_sync[1] == s_q.tx_sync[2])
      begin
         s_d.tx_level = s_q.tx_sync[2];
      end
      tx_rise = (s_q.tx_sync[1] == s_q.tx_sync[2]) && s_q.tx_sync[2]
         && !s_q.tx_level;

      // ==========================================
      // Register port
      if (reg_wr_in)
      begin
         if (reg_addr_in == `OSC_ADDR)
         begin
            s_d.osc = reg_wdata_in;
         end
         if (reg_addr_in == `SLC_ADDR)
         begin
            s_d.slc = reg_wdata_in;
         end
         for (int i = 0; i < `TAG_POSITIONS; i++)
         begin
            if (reg_addr_in == `TAG_SEL_ADDR0 + 8'(i))
            begin
               s_d.tag_sel[i] = reg_wdata_in[3:0];
            end
         end
      end
      if (reg_rd_in)
      begin
         if (reg_addr_in == `OSC_ADDR)
         begin
            s_d.rdata = s_q.osc;
         end
         if (reg_addr_in == `SLC_ADDR)
         begin
            s_d.rdata = s_q.slc;
         end
         for (int i = 0; i < `TAG_POSITIONS; i++)
         begin
            if (reg_addr_in == `TAG_SEL_ADDR0 + 8'(i))
            begin
               s_d.rdata = {4'h0, s_q.tag_sel[i]};
            end
         end
         if (reg_addr_in == `STATUS_ADDR)
         begin
            s_d.rdata = {3'h0, s_q.wait_cnt, s_q.phase};
         end
         if (reg_addr_in == `KEY_LOW_ADDR)
         begin
            s_d.rdata = s_q.lfsr[7:0];
         end
      end

      // ==========================================
      // Decode controls
      mode = s_q.osc[`OSC_MODE_HI:`OSC_MODE_LO];
      sub = s_q.osc[`OSC_SUB_HI:`OSC_SUB_LO];
      pair_dis = s_q.slc[`SLC_PAIR_DIS];
      unique case (channel_mode_in)
         2'b00, 2'b01: lat = `LAT_1CH;
         2'b10: lat = `LAT_2CH;
         2'b11: lat = `LAT_3CH;
      endcase
      unique case (sub)
         2'b00: k = `K_SUB00;
         2'b01: k = pair_dis ? `K_SUB01_NARROW : `K_SUB01_WIDE;
         2'b10: k = `K_SUB10;
         2'b11: k = `K_SUB11;
      endcase

      // ==========================================
      // Tag delay line
      tag_now.legacy = pixel_tag_bits_in;
      tag_now.red = red_pixel_in;
      tag_now.green = green_pixel_in;
      tag_now.blue = blue_pixel_in;
      tag_now.ping = ping_section_in;
      tag_now.line_idx = line_index_in;
      tag_now.black_loop = black_loop_in;
      tag_now.white_loop = white_loop_in;
      tag_now.clamp = input_clamp_switch_in;
      if (s_q.slc[`SLC_LAT_OFF])
      begin
         tag_use = tag_now;
      end
      else
      begin
         tag_use = s_q.tag_dly[lat - 3'h1];
      end

      // ==========================================
      // Word assembly
      w = {pixel_data_in, tag_use.legacy};
      for (int i = 0; i < `TAG_POSITIONS; i++)
      begin
         p = slot_pos(i);
         // Low data slots only when narrow
         if (i < `TAG_CB_POSITIONS || pair_dis)
         begin
            unique case (s_q.tag_sel[i])
               4'h0: w[p] = w[p];
               4'h1: w[p] = tag_use.legacy[0];
               4'h2: w[p] = tag_use.legacy[1];
               4'h3: w[p] = tag_use.legacy[2];
               4'h4: w[p] = tag_use.legacy[3];
               4'h5: w[p] = tag_use.legacy[4];
               4'h6: w[p] = tag_use.red;
               4'h7: w[p] = tag_use.green;
               4'h8: w[p] = tag_use.blue;
               4'h9:
               begin
                  w[p] = 1'b0;
                  par_pos[p] = 1'b1;
               end
               4'ha: w[p] = tag_use.ping;
               4'hb: w[p] = tag_use.line_idx[0];
               4'hc: w[p] = tag_use.line_idx[1];
               4'hd: w[p] = tag_use.black_loop;
               4'he: w[p] = tag_use.white_loop;
               4'hf: w[p] = tag_use.clamp;
            endcase
         end
      end

      // ==========================================
      // Parity
      // Lowest pair dropped from the word
      incl = pair_dis ? {{14{1'b1}}, {`LOW_PAIR_BITS{1'b0}}} : '1;
      incl = incl & ~par_pos;
      if (mode == 2'b10)
      begin
         incl[k] = 1'b0;
      end
      par = ^(w & incl);
      w = w | (par_pos & {21{par}});

      // ==========================================
      // Scrambler
      // Twenty-one shifts at once
      key_par = s_q.lfsr;
      for (int i = 0; i < `WORD_W; i++)
      begin
         key_par = key_step(key_par);
      end
      unique case (mode)
         2'b00: out = w;
         2'b01:
         begin
            unique case (sub)
               2'b00: out = w ^ s_q.lfsr;
               2'b01: out = s_q.lfsr;
               2'b10: out = w ^ s_q.lfsr;
               2'b11: out = s_q.lfsr;
            endcase
         end
         2'b10:
         begin
            out = w;
            out[k] = 1'b0;
            out = out ^ {21{s_q.lfsr[0]}};
         end
         // Data bit k keys the rest
         2'b11:
         begin
            out = w ^ {21{w[k]}};
            out[k] = w[k];
         end
      endcase
      if (pair_dis)
      begin
         out[`LOW_PAIR_BITS - 1:0] = '0;
      end

      // ==========================================
      // Key sequencing
      s_d.bol = line_start_in;
      if (line_start_in)
      begin
         s_d.phase = serial_output_tag_scrambler_pkg::KEY_IDLE;
         s_d.lfsr = `KEY_PRELOAD;
         s_d.wait_cnt = '0;
      end
      else if (s_q.bol)
      begin
         s_d.phase = serial_output_tag_scrambler_pkg::KEY_WAIT;
      end

      if (tx_rise)
      begin
         s_d.word = out;
         s_d.strobe = 1'b1;
         s_d.tag_dly[0] = tag_now;
         for (int i = 1; i < `DLY_DEPTH; i++)
         begin
            s_d.tag_dly[i] = s_q.tag_dly[i - 1];
         end
         if (!line_start_in)
         begin
            unique case (s_q.phase)
               // Idle must not undo the wait entry made above
               serial_output_tag_scrambler_pkg::KEY_IDLE:
                  s_d.wait_cnt = '0;
               serial_output_tag_scrambler_pkg::KEY_WAIT:
               begin
                  s_d.wait_cnt = s_q.wait_cnt + 3'h1;
                  if (s_q.wait_cnt == lat - 3'h1)
                  begin
                     s_d.phase = serial_output_tag_scrambler_pkg::KEY_RUN;
                  end
               end
               serial_output_tag_scrambler_pkg::KEY_RUN:
               begin
                  if (mode == 2'b01 && sub[1])
                  begin
                     s_d.lfsr = key_par;
                  end
                  else
                  begin
                     s_d.lfsr = key_step(s_q.lfsr);
                  end
               end
               default: s_d.phase = serial_output_tag_scrambler_pkg::KEY_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s_q <= '0;
         s_q.phase <= serial_output_tag_scrambler_pkg::KEY_IDLE;
         s_q.lfsr <= `KEY_PRELOAD;
         s_q.osc <= `OSC_RESET;
         s_q.slc <= `SLC_RESET;
         s_q.tag_sel <= {`TAG_POSITIONS{`TAG_SEL_RESET}};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_out = s_q.rdata;
   assign word_out = s_q.word;
   assign word_strobe_out = s_q.strobe;

endmodule

`default_nettype wire

/* File: include/serial_output_tag_scrambler_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_OUTPUT_TAG_SCRAMBLER_MAP_SVH
`define SERIAL_OUTPUT_TAG_SCRAMBLER_MAP_SVH

// ==========================================
// Register offsets
`define OSC_ADDR 8'h05
`define SLC_ADDR 8'h08
`define TAG_SEL_ADDR0 8'h10
`define STATUS_ADDR 8'h18
`define KEY_LOW_ADDR 8'h19

// ==========================================
// Fields
`define OSC_MODE_HI 4
`define OSC_MODE_LO 3
`define OSC_SUB_HI 2
`define OSC_SUB_LO 1
`define SLC_PAIR_DIS 1
`define SLC_LAT_OFF 2

// ==========================================
// Reset values
`define OSC_RESET 8'h00
`define SLC_RESET 8'h00
`define TAG_SEL_RESET 4'h0

// ==========================================
// Widths and counts
`define WORD_W 21
`define TAG_POSITIONS 7
`define TAG_CB_POSITIONS 5
`define LOW_PAIR_BITS 7
`define DATA_LSB 5
`define DLY_DEPTH 8
`define KEY_PRELOAD 21'h000001
`define KEY_TAP 2
`define LAT_1CH 3'h4
`define LAT_2CH 3'h5
`define LAT_3CH 3'h6

// ==========================================
// Key positions
`define K_SUB00 5'h00
`define K_SUB01_WIDE 5'h05
`define K_SUB01_NARROW 5'h07
`define K_SUB10 5'h10
`define K_SUB11 5'h14

`endif

/* File: include/serial_output_tag_scrambler_pkg.sv */
// Types of the serial output tag and scrambler stage
package serial_output_tag_scrambler_pkg;

   typedef struct packed {
      logic [4:0] legacy;
      logic red;
      logic green;
      logic blue;
      logic ping;
      logic [1:0] line_idx;
      logic black_loop;
      logic white_loop;
      logic clamp;
   } tag_t;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_WAIT = 2'b01,
      KEY_RUN = 2'b11
   } key_phase_t;

   typedef enum logic [3:0] {
      SEL_ORIG = 4'h0,
      SEL_LEG0 = 4'h1,
      SEL_LEG1 = 4'h2,
      SEL_LEG2 = 4'h3,
      SEL_LEG3 = 4'h4,
      SEL_LEG4 = 4'h5,
      SEL_RED = 4'h6,
      SEL_GREEN = 4'h7,
      SEL_BLUE = 4'h8,
      SEL_PARITY = 4'h9,
      SEL_PING = 4'ha,
      SEL_LINE_LSB = 4'hb,
      SEL_LINE_MSB = 4'hc,
      SEL_BLACK = 4'hd,
      SEL_WHITE = 4'he,
      SEL_CLAMP = 4'hf
   } tag_sel_t;

   typedef struct packed {
      logic [2:0] tx_sync;
      logic tx_level;
      tag_t [7:0] tag_dly;
      logic [20:0] lfsr;
      key_phase_t phase;
      logic [2:0] wait_cnt;
      logic bol;
      logic [20:0] word;
      logic strobe;
      logic [7:0] osc;
      logic [7:0] slc;
      logic [6:0][3:0] tag_sel;
      logic [7:0] rdata;
   } state_t;

endpackage

/* File: bench/serial_output_tag_scrambler_assertions.sv */
// Port checker for the tag and scrambler stage
`include "serial_output_tag_scrambler_map.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_output_tag_scrambler_checker
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic transmit_clock_in,
   input wire logic line_start_in,
   input wire logic [20:0] word_out,
   input wire logic word_strobe_out
);
   // ====
   // Shadow config
   logic [7:0] osc_q;
   logic [7:0] slc_q;
   logic [3:0] live_q;
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         osc_q <= 8'h00;
         slc_q <= 8'h00;
         live_q <= 4'h0;
      end
      else
      begin
         // Sync stages still settling
         if (live_q != 4'hf)
            live_q <= live_q + 4'h1;
         if (reg_wr_in && reg_addr_in == `OSC_ADDR)
            osc_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `SLC_ADDR)
            slc_q <= reg_wdata_in;
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence tx_rise;
      live_q == 4'hf && $rose(transmit_clock_in);
   endsequence
   sequence start_held;
      (line_start_in && $stable(osc_q)) [*8];
   endsequence
   rd_idle_zero_a: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero while idle");
   rd_ctrl_a: assert property (
      reg_rd_in && reg_addr_in == `OSC_ADDR |=> reg_rdata_out == osc_q)
      else $error("control readback wrong");
   word_hold_a: assert property (
      !word_strobe_out |-> $stable(word_out))
      else $error("word changed without strobe");
   strobe_pulse_a: assert property (
      word_strobe_out |=> !word_strobe_out [*8])
      else $error("strobes too close");
   strobe_after_rise_a: assert property (
      tx_rise |-> ##[2:6] word_strobe_out)
      else $error("no word after transmit rise");
   // Word was formed with the config of the cycle before
   pair_drop_a: assert property (
      word_strobe_out && $past(slc_q[`SLC_PAIR_DIS])
      |-> word_out[6:0] == 7'h00)
      else $error("dropped pair bits not zero");
   key_preload_a: assert property (
      start_held ##0 (word_strobe_out && osc_q[4:3] == 2'b01 && osc_q[1])
      |-> word_out == `KEY_PRELOAD)
      else $error("key not at preload during line start");
   key_only_gap_a: assert property (
      word_strobe_out && $past(osc_q[4:1]) == 4'b0101 && word_out[20]
      |-> word_out[19:0] == 20'h00000 || word_out[0])
      else $error("serial key left its sequence");
endmodule
bind serial_output_tag_scrambler serial_output_tag_scrambler_checker chk
(
   .clk_in(clk_in),
   .rst_b_in(rst_b_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .transmit_clock_in(transmit_clock_in),
   .line_start_in(line_start_in),
   .word_out(word_out),
   .word_strobe_out(word_strobe_out)
);
`default_nettype wire

/* File: bench/serial_link_receiver.sv */
// Far-side model: free-running transmit clock source
`timescale 1ns/1ps
`default_nettype none
module serial_link_receiver
(
   output logic transmit_clock_out
);
   // Offset keeps it unrelated to clk_in
   initial
   begin
      transmit_clock_out = 1'b0;
      #17;
      forever #62.5 transmit_clock_out = ~transmit_clock_out;
   end
endmodule
`default_nettype wire

/* File: bench/serial_output_tag_scrambler_bench.sv */
// Self-checking bench for the tag and scrambler stage
`include "serial_output_tag_scrambler_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define check(g, e) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("[FAIL] %0t got %h exp %h", $time, g, e); \
      end \
   end
module serial_output_tag_scrambler_bench;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] rdata;
   logic txc;
   logic line_start = 1'b1;
   logic [1:0] chmode = 2'b00;
   logic [15:0] data = 16'h0000;
   logic [13:0] flags = 14'h0000;
   logic [20:0] word;
   logic strobe;
   int mismatches = 0;
   int compares = 0;
   always #4 clk_in = ~clk_in;
   serial_link_receiver far (.transmit_clock_out(txc));
   serial_output_tag_scrambler dut
   (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_wr_in(wr_s),
      .reg_rd_in(rd_s),
      .reg_rdata_out(rdata),
      .transmit_clock_in(txc),
      .line_start_in(line_start),
      .channel_mode_in(chmode),
      .pixel_data_in(data),
      .pixel_tag_bits_in(flags[13:9]),
      .red_pixel_in(flags[8]),
      .green_pixel_in(flags[7]),
      .blue_pixel_in(flags[6]),
      .ping_section_in(flags[5]),
      .line_index_in(flags[4:3]),
      .black_loop_in(flags[2]),
      .white_loop_in(flags[1]),
      .input_clamp_switch_in(flags[0]),
      .word_out(word),
      .word_strobe_out(strobe)
   );
   // ====
   // Bus and link helpers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      @(negedge clk_in);
      d = rdata;
   endtask
   task automatic px(input logic [13:0] f, input logic [15:0] d);
      @(posedge clk_in);
      flags <= f;
      data <= d;
   endtask
   task automatic nxt(output logic [20:0] w);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_in);
         n++;
      end
      while (strobe !== 1'b1 && n < 40);
      // A stuck link counts as a mismatch
      if (n >= 40)
         mismatches++;
      w = word;
   endtask
   task automatic settle(output logic [20:0] w);
      nxt(w);
      nxt(w);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ====
   // Scenarios
   task automatic t_regs();
      logic [7:0] d;
      wr(`OSC_ADDR, 8'h1e);
      rd(`OSC_ADDR, d);
      `check(d, 8'h1e)
      wr(`TAG_SEL_ADDR0, 8'hff);
      rd(`TAG_SEL_ADDR0, d);
      `check(d, 8'h0f)
      rd(8'h30, d);
      `check(d, 8'h00)
      rd(`STATUS_ADDR, d);
      `check(d, 8'h00)
      rd(`KEY_LOW_ADDR, d);
      `check(d, 8'h01)
      wr(`OSC_ADDR, 8'h00);
   endtask
   task automatic t_tags();
      logic [20:0] w;
      logic [20:0] w0;
      logic [15:0] ev;
      logic [13:0] f;
      wr(`SLC_ADDR, 8'h04);
      for (int p = 0; p < 2; p++)
      begin
         f = p ? 14'h2a5b : 14'h15a4;
         w0 = {(p ? 16'ha5c3 : 16'h5a3c), f[13:9]};
         px(f, w0[20:5]);
         ev = {f[0], f[1], f[2], f[4], f[3], f[5], ^w0[20:1],
            f[6], f[7], f[8], f[13:9], w0[0]};
         for (int c = 0; c < 16; c++)
         begin
            wr(`TAG_SEL_ADDR0, 8'(c));
            settle(w);
            `check(w, {w0[20:1], ev[c]})
         end
      end
      wr(`TAG_SEL_ADDR0, 8'h00);
   endtask
   task automatic t_lat();
      logic [20:0] w;
      wr(`SLC_ADDR, 8'h00);
      px(14'h0000, 16'h1234);
      repeat (10) nxt(w);
      px(14'h3e00, 16'h1234);
      settle(w);
      `check(w[4:0], 5'h00)
      repeat (8) nxt(w);
      `check(w[4:0], 5'h1f)
   endtask
   task automatic t_drop();
      logic [20:0] w;
      logic [20:0] e;
      wr(`SLC_ADDR, 8'h06);
      wr(`TAG_SEL_ADDR0 + 8'h05, 8'h09);
      wr(`TAG_SEL_ADDR0 + 8'h06, 8'h06);
      px(14'h0100, 16'hb6d8);
      settle(w);
      e = {16'hb6d8, 5'h00};
      e[8] = 1'b1;
      e[7] = ^e[20:8];
      `check(w, e)
      wr(`TAG_SEL_ADDR0 + 8'h05, 8'h00);
      wr(`TAG_SEL_ADDR0 + 8'h06, 8'h00);
   endtask
   task automatic t_scr();
      logic [20:0] w;
      logic [20:0] e;
      logic [20:0] w0;
      int k;
      w0 = {16'hc3a5, 5'h15};
      wr(`SLC_ADDR, 8'h04);
      px(14'h2b00, 16'hc3a5);
      for (int i = 8; i < 16; i++)
      begin
         k = (i % 4 == 0) ? 0 : (i % 4 == 1) ? 5 : (i % 4 == 2) ? 16 : 20;
         wr(`OSC_ADDR, 8'(i * 2));
         settle(w);
         e = w0;
         e[k] = 1'b0;
         e = (i < 12) ? ~e : w0 ^ {21{w0[k]}};
         e[k] = (i < 12) ? 1'b1 : w0[k];
         `check(w, e)
      end
      wr(`SLC_ADDR, 8'h06);
      wr(`OSC_ADDR, 8'h1a);
      settle(w);
      e = w0 ^ {21{w0[7]}};
      e[7] = w0[7];
      e[6:0] = 7'h00;
      `check(w, e)
      wr(`SLC_ADDR, 8'h04);
      for (int s = 0; s < 2; s++)
      begin
         wr(`OSC_ADDR, s ? 8'h0c : 8'h08);
         settle(w);
         `check(w, w0 ^ `KEY_PRELOAD)
      end
   endtask
   task automatic t_key(input logic [7:0] o, input logic [20:0] a,
      input logic [20:0] b);
      logic [20:0] w;
      int n;
      wr(`OSC_ADDR, o);
      settle(w);
      `check(w, `KEY_PRELOAD)
      @(posedge clk_in);
      line_start <= 1'b0;
      n = 0;
      do
      begin
         nxt(w);
         n++;
      end
      while (w === `KEY_PRELOAD && n < 12);
      `check(n >= 3 && n <= 8, 1'b1)
      `check(w, a)
      nxt(w);
      `check(w, b)
      @(posedge clk_in);
      line_start <= 1'b1;
   endtask
   function automatic logic [20:0] rx_key(input int steps);
      logic [20:0] k;
      k = `KEY_PRELOAD;
      for (int i = 0; i < steps; i++)
      begin
         k = {k[0] ^ k[`KEY_TAP], k[20:1]};
      end
      return k;
   endfunction
   // Three-channel latency, then undo the key at the far end
   task automatic t_descr();
      logic [20:0] w;
      logic [20:0] w0;
      int n;
      w0 = {16'hc3a5, 5'h15};
      @(posedge clk_in);
      chmode <= 2'b11;
      wr(`OSC_ADDR, 8'h08);
      settle(w);
      @(posedge clk_in);
      line_start <= 1'b0;
      n = 0;
      do
      begin
         nxt(w);
         n++;
      end
      while ((w ^ w0) === `KEY_PRELOAD && n < 14);
      `check(n >= 7 && n <= 9, 1'b1)
      for (int j = 1; j < 4; j++)
      begin
         `check(w ^ rx_key(j), w0)
         nxt(w);
      end
      @(posedge clk_in);
      line_start <= 1'b1;
   endtask
   // ====
   // Main sequence and watchdog
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_regs();
      t_tags();
      t_lat();
      t_drop();
      t_scr();
      t_key(8'h0a, 21'h100000, 21'h080000);
      t_key(8'h0e, 21'h080001, 21'h020001);
      t_descr();
      summarize();
   end
   initial
   begin
      #400000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
